// ---- hw/dsw_defines.svh ----
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH
`define DSW_CMD_NOP      3'h0
`define DSW_CMD_DIAG     3'h1
`define DSW_CMD_OUTCFG   3'h2
`define DSW_CMD_IOCFG    3'h3
`define DSW_CMD_RESET    3'h4
`define DSW_CMD_SLEEP    3'h5
`define DSW_CMD_WAKE     3'h6
`define DSW_CMD_CHAN     3'h7
`define DSW_CLK_MHZ      125
`define DSW_FILT_US      50
`define DSW_OFF_US       100
`define DSW_WAKE_US      100
`define DSW_FILT_CYC     (`DSW_FILT_US * `DSW_CLK_MHZ)
`define DSW_OFF_CYC      (`DSW_OFF_US * `DSW_CLK_MHZ)
`define DSW_WAKE_CYC     (`DSW_WAKE_US * `DSW_CLK_MHZ)
`define DSW_DIAG_OK      2'h3
`define DSW_DIAG_OVL     2'h2
`define DSW_SRC_PAR      2'h0
`define DSW_SRC_OR       2'h1
`define DSW_SRC_AND      2'h2
`define DSW_SRC_SER      2'h3
`define DSW_PINA_FAULT   2'h0
`endif

// ---- hw/dsw_pkg.sv ----
package dsw_pkg;
	typedef struct packed {
		logic [1:0] lim1;
		logic       latch;
		logic [1:0] slow;
	} dsw_outcfg_t;
	typedef struct packed {
		logic       spi_mode;
		logic [1:0] src;
		logic [1:0] pina_fn;
	} dsw_iocfg_t;
	typedef enum logic [1:0] {DSW_RUN, DSW_SLEEP, DSW_WAKING} dsw_pwr_t;
endpackage

// ---- hw/dsw_ctrl.sv ----
`include "dsw_defines.svh"
module dsw_ctrl
	import dsw_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] par_in_i,
	input  wire logic [1:0] chan_ot_i,
	input  wire logic [1:0] chan_lim_i,
	input  wire logic       die_warn_i,
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       si_i,
	output logic      [1:0] chan_on_o,
	output logic      [1:0] slow_slew_o,
	output logic      [1:0] lim1_mode_o,
	output logic            die_warn_o,
	output logic            bias_en_o,
	output logic      [1:0] sense_sel_o,
	output logic            pin_a_o,
	output logic            pin_a_oe_o,
	output logic            pin_b_o,
	output logic            pin_b_oe_o
);
	////////////////////////////////////////////////////////////
	// Input synchronisers: every input pin except clk_i and rst_i passes two flops
	logic [9:0] sync1;
	logic [9:0] sync2;
	logic [9:0] next_sync1;
	always_comb begin
		next_sync1 = {par_in_i, chan_ot_i, chan_lim_i, die_warn_i, cs_n_i, sclk_i, si_i};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 10'h004;
			sync2 <= 10'h004;
		end else begin
			sync1 <= next_sync1;
			sync2 <= sync1;
		end
	end
	logic [1:0] par_s;
	logic [1:0] ot_s;
	logic [1:0] lim_s;
	logic       cs_s;
	logic       sclk_s;
	logic       si_s;
	assign par_s  = sync2[9:8];
	assign ot_s   = sync2[7:6];
	assign lim_s  = sync2[5:4];
	assign cs_s   = sync2[2];
	assign sclk_s = sync2[1];
	assign si_s   = sync2[0];

	////////////////////////////////////////////////////////////
	// Serial link
	logic        cs_d;
	logic        sclk_d;
	logic [7:0]  shreg;
	logic        so_bit;
	logic [7:0]  next_shreg;
	logic        next_so_bit;
	logic        cs_fall;
	logic        cs_rise;
	logic        sck_fall;
	logic        sck_rise;
	dsw_pwr_t    pwr;
	logic [7:0]  diag;
	assign cs_fall  = cs_d & ~cs_s;
	assign cs_rise  = ~cs_d & cs_s;
	assign sck_fall = ~cs_s & sclk_d & ~sclk_s;
	assign sck_rise = ~cs_s & ~sclk_d & sclk_s;
	always_comb begin
		next_shreg  = shreg;
		next_so_bit = so_bit;
		if (cs_fall) begin
			if (pwr != DSW_SLEEP) begin
				next_shreg = diag;
			end
			next_so_bit = (pwr != DSW_SLEEP) ? diag[7] : shreg[7];
		end else if (sck_fall) begin
			next_shreg = {shreg[6:0], si_s};
		end else if (sck_rise) begin
			next_so_bit = shreg[6];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_d   <= 1'b1;
			sclk_d <= 1'b0;
			shreg  <= 8'h00;
			so_bit <= 1'b1;
		end else begin
			cs_d   <= cs_s;
			sclk_d <= sclk_s;
			shreg  <= next_shreg;
			so_bit <= next_so_bit;
		end
	end

	////////////////////////////////////////////////////////////
	// Command decode and configuration
	dsw_outcfg_t ocfg;
	dsw_iocfg_t  iocfg;
	logic [1:0]  ser_on;
	logic [15:0] wake_cnt;
	dsw_outcfg_t next_ocfg;
	dsw_iocfg_t  next_iocfg;
	logic [1:0]  next_ser_on;
	dsw_pwr_t    next_pwr;
	logic [15:0] next_wake_cnt;
	logic        diag_clr;
	logic [2:0]  cmd;
	assign cmd = shreg[7:5];
	always_comb begin
		next_ocfg     = ocfg;
		next_iocfg    = iocfg;
		next_ser_on   = ser_on;
		next_pwr      = pwr;
		next_wake_cnt = wake_cnt;
		diag_clr      = 1'b0;
		if (pwr == DSW_WAKING) begin
			if (wake_cnt == 16'(`DSW_WAKE_CYC - 1)) begin
				next_pwr = DSW_RUN;
			end else begin
				next_wake_cnt = wake_cnt + 16'h0001;
			end
		end
		if (cs_rise) begin
			case (pwr)
				DSW_SLEEP: begin
					if (cmd == `DSW_CMD_WAKE) begin
						next_pwr      = DSW_WAKING;
						next_wake_cnt = 16'h0000;
						diag_clr      = 1'b1;
					end
				end
				default: begin
					diag_clr = (cmd != `DSW_CMD_NOP);
					case (cmd)
						`DSW_CMD_OUTCFG: next_ocfg = shreg[4:0];
						`DSW_CMD_IOCFG: next_iocfg = shreg[4:0];
						`DSW_CMD_RESET: begin
							next_ocfg   = 5'h00;
							next_iocfg  = 5'h00;
							next_ser_on = 2'h0;
						end
						`DSW_CMD_SLEEP: begin
							next_pwr    = DSW_SLEEP;
							next_ser_on = 2'h0;
						end
						`DSW_CMD_CHAN: next_ser_on = shreg[4:3];
						default: next_ser_on = ser_on;
					endcase
				end
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ocfg     <= 5'h00;
			iocfg    <= 5'h00;
			ser_on   <= 2'h0;
			pwr      <= DSW_RUN;
			wake_cnt <= 16'h0000;
		end else begin
			ocfg     <= next_ocfg;
			iocfg    <= next_iocfg;
			ser_on   <= next_ser_on;
			pwr      <= next_pwr;
			wake_cnt <= next_wake_cnt;
		end
	end

	////////////////////////////////////////////////////////////
	// Channel control and protection
	function automatic logic req_sel(input logic [1:0] src, input logic p, input logic s);
		case (src)
			`DSW_SRC_PAR: req_sel = p;
			`DSW_SRC_OR:  req_sel = p | s;
			`DSW_SRC_AND: req_sel = p & s;
			default:      req_sel = s;
		endcase
	endfunction
	logic [1:0]  req;
	logic [1:0]  req_d;
	logic [1:0]  ot_latch;
	logic [1:0]  ovl_latch;
	logic [1:0]  on_q;
	logic [14:0] lim_cnt [2];
	logic [1:0]  next_req_d;
	logic [1:0]  next_ot_latch;
	logic [1:0]  next_ovl_latch;
	logic [1:0]  next_on_q;
	logic [14:0] next_lim_cnt [2];
	logic [7:0]  next_diag;
	logic        awake;
	assign awake = (pwr == DSW_RUN);
	always_comb begin
		next_diag = diag_clr ? 8'hFF : diag;
		for (int c = 0; c < 2; c++) begin
			req[c]            = req_sel(iocfg.src, par_s[c], ser_on[c]);
			next_req_d[c]     = req[c];
			next_ot_latch[c]  = ot_latch[c];
			next_ovl_latch[c] = ovl_latch[c];
			next_lim_cnt[c]   = 15'h0000;
			if (req[c] & ~req_d[c]) begin
				next_ot_latch[c]  = 1'b0;
				next_ovl_latch[c] = 1'b0;
			end
			if (on_q[c] & ot_s[c]) begin
				next_ot_latch[c] = 1'b1;
				next_diag[2*c +: 2] = `DSW_DIAG_OVL;
			end
			if (on_q[c] & lim_s[c]) begin
				next_lim_cnt[c] = lim_cnt[c] + 15'h0001;
				if (ocfg.lim1[c] && lim_cnt[c] >= 15'(`DSW_FILT_CYC)) begin
					next_diag[2*c +: 2] = `DSW_DIAG_OVL;
					next_lim_cnt[c]     = lim_cnt[c];
				end else if (!ocfg.lim1[c] && lim_cnt[c] >= 15'(`DSW_OFF_CYC)) begin
					next_ovl_latch[c]   = 1'b1;
					next_diag[2*c +: 2] = `DSW_DIAG_OVL;
					next_lim_cnt[c]     = lim_cnt[c];
				end
			end
			// Autorestart: with latch clear, the latch falls when the sensor cools, requested or not
			if (!ocfg.latch && ot_latch[c] && !ot_s[c]) begin
				next_ot_latch[c] = 1'b0;
			end
			next_on_q[c] = awake & req[c] & ~next_ot_latch[c] & ~next_ovl_latch[c];
		end
		if (pwr != DSW_RUN) begin
			next_diag = 8'hFF;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_d     <= 2'h0;
			ot_latch  <= 2'h0;
			ovl_latch <= 2'h0;
			on_q      <= 2'h0;
			lim_cnt   <= '{15'h0000, 15'h0000};
			diag      <= 8'hFF;
		end else begin
			req_d     <= next_req_d;
			ot_latch  <= next_ot_latch;
			ovl_latch <= next_ovl_latch;
			on_q      <= next_on_q;
			lim_cnt   <= next_lim_cnt;
			diag      <= {next_diag[7:6], ~sync2[3], next_diag[4:0]};
		end
	end

	////////////////////////////////////////////////////////////
	// Outputs and multi-function pins
	logic [1:0] ch_err;
	logic       pa;
	logic       pa_oe;
	logic       pb;
	logic       pb_oe;
	logic       next_pa;
	logic       next_pa_oe;
	logic       next_pb;
	logic       next_pb_oe;
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ch_err[c] = (diag[2*c +: 2] != `DSW_DIAG_OK);
		end
		next_pa    = 1'b0;
		next_pa_oe = 1'b0;
		if (!iocfg.spi_mode) begin
			next_pa    = req[0] ^ ch_err[0];
			next_pa_oe = 1'b1;
		end else if (iocfg.pina_fn == `DSW_PINA_FAULT) begin
			next_pa_oe = (diag[3:0] != 4'hF);
		end
		if (iocfg.spi_mode) begin
			next_pb    = so_bit;
			next_pb_oe = ~cs_s;
		end else begin
			next_pb    = req[1] ^ ch_err[1];
			next_pb_oe = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa    <= 1'b0;
			pa_oe <= 1'b0;
			pb    <= 1'b0;
			pb_oe <= 1'b0;
		end else begin
			pa    <= next_pa;
			pa_oe <= next_pa_oe;
			pb    <= next_pb;
			pb_oe <= next_pb_oe;
		end
	end
	assign chan_on_o   = on_q;
	assign slow_slew_o = ocfg.slow;
	assign lim1_mode_o = ocfg.lim1;
	assign die_warn_o  = ~diag[5];
	assign bias_en_o   = (pwr != DSW_SLEEP);
	assign sense_sel_o = (iocfg.spi_mode) ? iocfg.pina_fn : 2'h0;
	assign pin_a_o     = pa;
	assign pin_a_oe_o  = pa_oe;
	assign pin_b_o     = pb;
	assign pin_b_oe_o  = pb_oe;

	AST_SLEEP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		(pwr == DSW_SLEEP) |=> (chan_on_o == 2'h0))
		else $error("output on in sleep");
	AST_OT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		(on_q[0] & ot_s[0]) |=> !on_q[0])
		else $error("channel stayed on at overtemperature");
	AST_SO_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
		(cs_s && iocfg.spi_mode) |=> !pin_b_oe_o)
		else $error("serial out driven while deselected");
	AST_NOP_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
		(cs_rise && cmd == `DSW_CMD_NOP && pwr == DSW_RUN) |-> !diag_clr)
		else $error("no-op cleared diagnosis");
	AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		(cs_fall && pwr == DSW_RUN) |=> shreg == $past(diag))
		else $error("diagnosis not loaded");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(pwr == DSW_WAKING) |-> (pwr != DSW_RUN) [*8])
		else $error("woke too early");
	AST_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
		(iocfg.spi_mode && iocfg.pina_fn == `DSW_PINA_FAULT && diag[1:0] != 2'h3 && $stable(iocfg))
		|=> pin_a_oe_o)
		else $error("fault pin not pulled");
	AST_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
		(iocfg.src == `DSW_SRC_SER && ser_on == 2'h0) |=> chan_on_o == 2'h0)
		else $error("serial source ignored");
endmodule

// ---- tb/dsw_host.sv ----
module dsw_host (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      si_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o   = 1'b0;
	end

	////////////////////////////////////////
	// One frame of eight bits; a link period is 20 clocks.
	// SI moves mid-way through the low phase so that it never races the falling SCLK edge in the synchronisers.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			repeat (5) @(posedge clk_i);
			si_o <= tx[i];
			repeat (5) @(posedge clk_i);
			rx[i] = so_i;
			sclk_o <= 1'b1;
			repeat (10) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (10) @(posedge clk_i);
		// SCLK low at both chip-select edges; SI back at its pull-down level
		cs_n_o <= 1'b1;
		si_o   <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
endmodule

// ---- tb/dsw_ctrl_test.sv ----
`include "dsw_defines.svh"
module dsw_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk_i      = 1'b0;
	logic       rst_i      = 1'b1;
	logic [1:0] par_in_i   = 2'h0;
	logic [1:0] chan_ot_i  = 2'h0;
	logic [1:0] chan_lim_i = 2'h0;
	logic       die_warn_i = 1'b0;
	logic       cs_n, sclk, si, so_last = 1'b0;
	logic [1:0] chan_on, slow_slew, lim1_mode, sense_sel;
	logic       die_warn, bias_en, pin_a, pin_a_oe, pin_b, pin_b_oe;
	logic [7:0] rx;
	logic [1:0] exp_src [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
	int         miscompares = 0;
	int         num_checks  = 0;
	int         cycles      = 0;
	// Released SO toggles so a stale bit cannot pass; fault line has a pull-up
	wire        so       = pin_b_oe ? pin_b : ~so_last;
	wire        fault_ln = pin_a_oe ? pin_a : 1'b1;

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) so_last <= so;

	dsw_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .par_in_i(par_in_i), .chan_ot_i(chan_ot_i),
		.chan_lim_i(chan_lim_i), .die_warn_i(die_warn_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
		.chan_on_o(chan_on), .slow_slew_o(slow_slew), .lim1_mode_o(lim1_mode), .die_warn_o(die_warn),
		.bias_en_o(bias_en), .sense_sel_o(sense_sel), .pin_a_o(pin_a), .pin_a_oe_o(pin_a_oe),
		.pin_b_o(pin_b), .pin_b_oe_o(pin_b_oe));

	dsw_host host_u (.clk_i(clk_i), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

	////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmd(input logic [2:0] c, input logic [4:0] d);
		host_u.xfer({c, d}, rx);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Whole run is about 43k clocks
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			end_sim();
		end
	end

	////////////////////////////////////////
	initial begin
		tick(12);
		rst_i <= 1'b0;
		tick(4);
		chk("chan_on", chan_on, 2'h0);
		chk("slow_slew", slow_slew, 2'h0);
		chk("lim1_mode", lim1_mode, 2'h0);
		chk("bias_en", bias_en, 1'b1);
		par_in_i <= 2'h2;
		tick(6);
		chk("chan_on", chan_on, 2'h2);
		chk("pin_b", pin_b, 1'b1);
		par_in_i <= 2'h1;
		tick(6);
		chk("chan_on", chan_on, 2'h1);
		chk("pin_b", pin_b, 1'b0);
		chk("pin_a", pin_a, 1'b1);
		cmd(`DSW_CMD_IOCFG, 5'h1C);
		cmd(`DSW_CMD_CHAN, 5'h10);
		chk("chan_on", chan_on, 2'h2);
		for (int s = 0; s < 4; s++) begin
			cmd(`DSW_CMD_IOCFG, {1'b1, s[1:0], 2'h0});
			chk("chan_on src", chan_on, exp_src[s]);
		end
		cmd(`DSW_CMD_DIAG, 5'h00);
		chk("diag", rx, 8'hFF);
		chk("pin_b_oe", pin_b_oe, 1'b0);
		cmd(`DSW_CMD_OUTCFG, 5'h15);
		chk("lim1_mode", lim1_mode, 2'h2);
		chk("slow_slew", slow_slew, 2'h1);
		cmd(`DSW_CMD_CHAN, 5'h18);
		chan_ot_i <= 2'h1;
		tick(6);
		chk("chan_on", chan_on, 2'h2);
		chk("fault", fault_ln, 1'b0);
		chan_ot_i <= 2'h0;
		tick(20);
		chk("chan_on", chan_on, 2'h2);
		cmd(`DSW_CMD_NOP, 5'h00);
		chk("fault", fault_ln, 1'b0);
		cmd(`DSW_CMD_DIAG, 5'h00);
		chk("diag", rx, 8'hFE);
		chk("fault", fault_ln, 1'b1);
		cmd(`DSW_CMD_CHAN, 5'h10);
		chan_ot_i <= 2'h1;
		tick(20);
		chan_ot_i <= 2'h0;
		cmd(`DSW_CMD_DIAG, 5'h00);
		chk("diag", rx, 8'hFF);
		cmd(`DSW_CMD_CHAN, 5'h18);
		chk("chan_on", chan_on, 2'h3);
		die_warn_i <= 1'b1;
		tick(6);
		chk("die_warn", die_warn, 1'b1);
		cmd(`DSW_CMD_DIAG, 5'h00);
		chk("diag", rx, 8'hDF);
		die_warn_i <= 1'b0;
		chan_lim_i <= 2'h3;
		tick(7000);
		chk("chan_on", chan_on, 2'h3);
		tick(6000);
		chk("chan_on", chan_on, 2'h2);
		chan_lim_i <= 2'h0;
		cmd(`DSW_CMD_DIAG, 5'h00);
		chk("diag", rx, 8'hFA);
		for (int f = 1; f < 4; f++) begin
			cmd(`DSW_CMD_IOCFG, {3'h7, f[1:0]});
			chk("sense_sel", sense_sel, f[1:0]);
		end
		cmd(`DSW_CMD_SLEEP, 5'h00);
		chk("chan_on", chan_on, 2'h0);
		chk("bias_en", bias_en, 1'b0);
		cmd(`DSW_CMD_CHAN, 5'h18);
		chk("chan_on", chan_on, 2'h0);
		chk("shift", rx, 8'hA0);
		cmd(`DSW_CMD_WAKE, 5'h00);
		tick(`DSW_WAKE_CYC + 20);
		chk("bias_en", bias_en, 1'b1);
		chk("chan_on", chan_on, 2'h0);
		chk("lim1_mode", lim1_mode, 2'h2);
		cmd(`DSW_CMD_SLEEP, 5'h00);
		cmd(`DSW_CMD_WAKE, 5'h00);
		cmd(`DSW_CMD_CHAN, 5'h18);
		chk("chan_on", chan_on, 2'h0);
		tick(`DSW_WAKE_CYC);
		chk("chan_on", chan_on, 2'h3);
		cmd(`DSW_CMD_OUTCFG, 5'h10);
		chan_ot_i <= 2'h1;
		tick(6);
		chk("chan_on", chan_on, 2'h2);
		chan_ot_i <= 2'h0;
		tick(6);
		chk("chan_on", chan_on, 2'h3);
		end_sim();
	end
endmodule
